// ### pkg/ipf_params.svh
// Register offsets, field positions, reset values and widths of the priority and flag block.
`ifndef IPF_PARAMS_SVH
`define IPF_PARAMS_SVH
`define IPF_OFF_PRIO_A 8'h00
`define IPF_OFF_PRIO_B 8'h04
`define IPF_OFF_FLAGS 8'h08
`define IPF_OFF_SENSE 8'h0c
`define IPF_OFF_STANDBY 8'h10
`define IPF_OFF_STATUS 8'h14
`define IPF_RST_BYTE 8'h00
`define IPF_PIN_COUNT 6
`define IPF_SRC_COUNT 20
`define IPF_FLAG_MASK 8'h3f
`define IPF_A_PIN0 7
`define IPF_A_PIN1 6
`define IPF_A_PIN23 5
`define IPF_A_PIN45 4
`define IPF_A_WDRF 3
`define IPF_A_TMR0 2
`define IPF_A_TMR1 1
`define IPF_A_TMR2 0
`define IPF_B_TMR3 7
`define IPF_B_TMR4 6
`define IPF_B_DMA 5
`define IPF_B_SER0 3
`define IPF_B_SER1 2
`define IPF_B_ADC 1
`define IPF_NMI_CODE 5'h1f
`define IPF_NONE_CODE 5'h1e
`endif

// ### pkg/ipf_pkg.sv
// Types shared by the priority and flag block.
package ipf_pkg;
  typedef enum logic [1:0] {
    IPF_RD_IDLE = 2'b00,
    IPF_RD_RESP = 2'b01
  } ipf_rd_state_t;
  typedef logic [4:0] ipf_src_t;
endpackage

// ### rtl/ipf_ctrl.sv
// Interrupt priority registers, external pin request flags and level arbitration.
`timescale 1ns/100ps
`include "ipf_params.svh"
// Function
// [RL1] Priority A bit 7 sets pin 0 level.
// [RL2] Priority A bit 6 sets pin 1 level.
// [RL3] Priority A bit 5 sets shared level of pins 2 and 3.
// [RL4] Priority A bit 4 sets shared level of pins 4 and 5.
// [RL5] Priority A bit 3 sets shared level of watchdog and refresh.
// [RL6] Priority A bits 2..0 set timer channels 0..2 levels.
// [RL7] Priority B bits 7 and 6 set timer channels 3 and 4.
// [RL8] Priority B bit 5 sets shared level of both DMA channels.
// [RL9] Priority B bits 3 and 2 set serial channels 0 and 1.
// [RL10] Priority B bit 1 sets converter level.
// [RL11] Priority B bits 4 and 0 store and read back without effect.
// [RL12] Cleared bit means level 0, set bit means level 1.
// [RL13] Reset and hardware standby force all three registers to zero.
// [RL14] Flag register bits 7 and 6 read zero and are not writable.
// [RL15] Flag bits 5..0 hold the request of the same pin.
// [RL16] Level sense sets flag while pin is low.
// [RL17] Edge sense sets flag on a high to low pin change.
// [RL18] Software clears a flag by reading it as one, then writing zero.
// [RL19] Level sense clears flag on handling while the pin is high.
// [RL20] Edge sense clears flag when its handling is carried out.
// [RL21] Writes only clear flags; pins alone set them.
// [RL22] Sense bit zero means low level, one means falling edge.
// [RL23] Same-level requests go by smaller vector number first.
// [RL24] Nonmaskable request always wins above both levels.
// [RL25] Any level 1 request goes ahead of every level 0 request.
module ipf_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hwStandby,
  input wire logic [`IPF_PIN_COUNT-1:0] externalRequestPinN,
  input wire logic nmiReq,
  input wire logic [13:0] internalReq,
  input wire logic [`IPF_PIN_COUNT-1:0] pinHandled,
  output logic reqValid,
  output ipf_pkg::ipf_src_t reqSource,
  output logic reqLevel,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NSRC = `IPF_SRC_COUNT;
  logic [7:0] prioA_q;
  logic [7:0] prioB_q;
  logic [5:0] flags_q;
  logic [5:0] flags_d;
  logic [5:0] sense_q;
  logic [5:0] armed_q;
  logic [5:0] pinLast_q;
  logic [7:0] awAddr_q;
  logic awHave_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wHave_q;
  ipf_pkg::ipf_rd_state_t rdState_q;
  logic [NSRC-1:0] srcReq;
  logic [NSRC-1:0] srcLevel;
  logic [NSRC-1:0] hiReq;
  logic [NSRC-1:0] loReq;
  logic hiFound;
  logic loFound;
  ipf_pkg::ipf_src_t hiIdx;
  ipf_pkg::ipf_src_t loIdx;
  logic doWrite;
  logic flagWrite;
  logic [5:0] fallEdge;
  logic [5:0] setCond;
  logic [5:0] clrHandle;
  logic [5:0] clrSoft;
  logic flagRead;

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? data[7:0] : old;
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction

  // Write channel: address and data are taken in either order, response follows both.
  assign s_axi_awready = !awHave_q && !s_axi_bvalid;
  assign s_axi_wready = !wHave_q && !s_axi_bvalid;
  assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      awHave_q <= 1'b0;
      awAddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHave_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (doWrite) begin
      awHave_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wHave_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHave_q <= 1'b1;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (doWrite) begin
      wHave_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Priority registers; reserved bits of the second register are plain storage.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prioA_q <= `IPF_RST_BYTE;
      prioB_q <= `IPF_RST_BYTE;
      sense_q <= 6'h00;
    end else if (hwStandby) begin
      prioA_q <= `IPF_RST_BYTE; // see [RL13]
      prioB_q <= `IPF_RST_BYTE;
      sense_q <= 6'h00;
    end else if (doWrite) begin
      if (hit(awAddr_q, `IPF_OFF_PRIO_A)) begin
        prioA_q <= merge_byte(prioA_q, wData_q, wStrb_q);
      end
      if (hit(awAddr_q, `IPF_OFF_PRIO_B)) begin
        prioB_q <= merge_byte(prioB_q, wData_q, wStrb_q); // see [RL11]
      end
      if (hit(awAddr_q, `IPF_OFF_SENSE) && wStrb_q[0]) begin
        sense_q <= wData_q[5:0];
      end
    end
  end

  // Read channel with one response register.
  assign s_axi_arready = (rdState_q == ipf_pkg::IPF_RD_IDLE);
  assign s_axi_rresp = 2'b00;
  assign s_axi_rvalid = (rdState_q == ipf_pkg::IPF_RD_RESP);
  assign flagRead = s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `IPF_OFF_FLAGS);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdState_q <= ipf_pkg::IPF_RD_IDLE;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      case (rdState_q)
        ipf_pkg::IPF_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rdState_q <= ipf_pkg::IPF_RD_RESP;
            if (hit(s_axi_araddr, `IPF_OFF_PRIO_A)) begin
              s_axi_rdata <= {24'h000000, prioA_q};
            end else if (hit(s_axi_araddr, `IPF_OFF_PRIO_B)) begin
              s_axi_rdata <= {24'h000000, prioB_q};
            end else if (hit(s_axi_araddr, `IPF_OFF_FLAGS)) begin
              s_axi_rdata <= {26'h0000000, flags_q}; // see [RL14]
            end else if (hit(s_axi_araddr, `IPF_OFF_SENSE)) begin
              s_axi_rdata <= {26'h0000000, sense_q};
            end else if (hit(s_axi_araddr, `IPF_OFF_STATUS)) begin
              s_axi_rdata <= {24'h000000, reqValid, reqLevel, 1'b0, reqSource};
            end else begin
              s_axi_rdata <= 32'h0000_0000;
            end
          end
        end
        ipf_pkg::IPF_RD_RESP: begin
          if (s_axi_rready) begin
            rdState_q <= ipf_pkg::IPF_RD_IDLE;
          end
        end
        default: begin
          rdState_q <= ipf_pkg::IPF_RD_IDLE;
        end
      endcase
    end
  end

  // A flag may be cleared by software only after it was read as one.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      armed_q <= 6'h00;
    end else if (hwStandby) begin
      armed_q <= 6'h00;
    end else begin
      armed_q <= (flagRead ? flags_q : armed_q) & ~clrSoft; // see [RL18]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinLast_q <= 6'h3f;
    end else begin
      pinLast_q <= externalRequestPinN;
    end
  end

  assign flagWrite = doWrite && hit(awAddr_q, `IPF_OFF_FLAGS) && wStrb_q[0];
  assign fallEdge = pinLast_q & ~externalRequestPinN; // see [RL17]
  // Sense bit selects low level or falling edge per pin.
  assign setCond = (~sense_q & ~externalRequestPinN) | (sense_q & fallEdge); // see [RL22] [RL16]
  assign clrHandle = pinHandled & (sense_q | externalRequestPinN); // see [RL19] [RL20]
  assign clrSoft = flagWrite ? (armed_q & ~wData_q[5:0]) : 6'h00; // see [RL21]

  always_comb begin
    flags_d = (flags_q & ~clrHandle & ~clrSoft) | setCond; // see [RL15]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= 6'h00;
    end else if (hwStandby) begin
      flags_q <= 6'h00; // see [RL13]
    end else begin
      flags_q <= flags_d;
    end
  end

  // Sources in vector order: pins 0..5, watchdog, refresh, then internal peripherals.
  assign srcReq = {internalReq[11:0], internalReq[13:12], flags_q};
  always_comb begin
    srcLevel = '0;
    srcLevel[0] = prioA_q[`IPF_A_PIN0]; // see [RL1] [RL12]
    srcLevel[1] = prioA_q[`IPF_A_PIN1]; // see [RL2]
    srcLevel[2] = prioA_q[`IPF_A_PIN23]; // see [RL3]
    srcLevel[3] = prioA_q[`IPF_A_PIN23];
    srcLevel[4] = prioA_q[`IPF_A_PIN45]; // see [RL4]
    srcLevel[5] = prioA_q[`IPF_A_PIN45];
    srcLevel[6] = prioA_q[`IPF_A_WDRF]; // see [RL5]
    srcLevel[7] = prioA_q[`IPF_A_WDRF];
    srcLevel[8] = prioA_q[`IPF_A_TMR0]; // see [RL6]
    srcLevel[9] = prioA_q[`IPF_A_TMR1];
    srcLevel[10] = prioA_q[`IPF_A_TMR2];
    srcLevel[11] = prioB_q[`IPF_B_TMR3]; // see [RL7]
    srcLevel[12] = prioB_q[`IPF_B_TMR4];
    srcLevel[13] = prioB_q[`IPF_B_DMA]; // see [RL8]
    srcLevel[14] = prioB_q[`IPF_B_DMA];
    srcLevel[15] = prioB_q[`IPF_B_SER0]; // see [RL9]
    srcLevel[16] = prioB_q[`IPF_B_SER1];
    srcLevel[17] = prioB_q[`IPF_B_ADC]; // see [RL10]
    srcLevel[18] = prioB_q[`IPF_B_ADC];
    srcLevel[19] = prioB_q[`IPF_B_ADC];
  end

  assign hiReq = srcReq & srcLevel;
  assign loReq = srcReq & ~srcLevel;

  ipf_pick #(.N(NSRC)) u_hi (.req(hiReq), .found(hiFound), .index(hiIdx)); // see [RL23]
  ipf_pick #(.N(NSRC)) u_lo (.req(loReq), .found(loFound), .index(loIdx));

  // Presented request is registered; nonmaskable beats level 1, level 1 beats level 0.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reqValid <= 1'b0;
      reqSource <= `IPF_NONE_CODE;
      reqLevel <= 1'b0;
    end else if (nmiReq) begin
      reqValid <= 1'b1; // see [RL24]
      reqSource <= `IPF_NMI_CODE;
      reqLevel <= 1'b1;
    end else if (hiFound) begin
      reqValid <= 1'b1; // see [RL25]
      reqSource <= hiIdx;
      reqLevel <= 1'b1;
    end else begin
      reqValid <= loFound;
      reqSource <= loIdx;
      reqLevel <= 1'b0;
    end
  end

  nmi_wins_a: assert property (@(posedge core_clk) disable iff (!rstn)
    nmiReq |=> reqValid && reqSource == `IPF_NMI_CODE) else $error("nmi not first"); // see [RL24]
  level_one_first_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !nmiReq && |(srcReq & srcLevel) |=> reqLevel) else $error("level 1 lost"); // see [RL25]
  standby_clears_a: assert property (@(posedge core_clk) disable iff (!rstn)
    hwStandby |=> prioA_q == 8'h00 && prioB_q == 8'h00 && flags_q == 6'h00)
    else $error("standby left state"); // see [RL13]
  low_level_sets_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !hwStandby && !sense_q[0] && !externalRequestPinN[0] |=> flags_q[0])
    else $error("level flag missing"); // see [RL16]
  edge_sets_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !hwStandby && sense_q[1] && $fell(externalRequestPinN[1]) |=> flags_q[1])
    else $error("edge flag missing"); // see [RL17]
  edge_handled_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !hwStandby && sense_q[2] && pinHandled[2] && !setCond[2] |=> !flags_q[2])
    else $error("handled flag kept"); // see [RL20]
  no_blind_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    flags_q[3] && !armed_q[3] && !pinHandled[3] && !hwStandby |=> flags_q[3])
    else $error("unread flag cleared"); // see [RL18]
  write_cannot_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !flags_q[4] && !setCond[4] |=> !flags_q[4]) else $error("flag set by write"); // see [RL21]
  pin0_level_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !nmiReq && flags_q[0] && prioA_q[7] |=> reqLevel) else $error("pin 0 level wrong"); // see [RL1]
  dma_shared_a: assert property (@(posedge core_clk) disable iff (!rstn)
    srcReq == 20'h02000 && !nmiReq |=> reqLevel == $past(prioB_q[5]) && reqSource == 5'h0d)
    else $error("dma level wrong"); // see [RL8]
  flag_top_zero_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [RL14]
    flagRead |=> s_axi_rdata[7:6] == 2'b00) else $error("reserved flag bits set");
  prio_b_store_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [RL11]
    !hwStandby && doWrite && hit(awAddr_q, `IPF_OFF_PRIO_B) && wStrb_q[0]
    |=> prioB_q == $past(wData_q[7:0])) else $error("prio b not stored");
  prio_a_store_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [RL1]
    !hwStandby && doWrite && hit(awAddr_q, `IPF_OFF_PRIO_A) && wStrb_q[0]
    |=> prioA_q == $past(wData_q[7:0])) else $error("prio a not stored");
  level_handled_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [RL19]
    !hwStandby && !sense_q[0] && pinHandled[0] && externalRequestPinN[0] |=> !flags_q[0])
    else $error("level flag kept");
  pin5_flag_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [RL15]
    !hwStandby && sense_q[5] && $fell(externalRequestPinN[5]) |=> flags_q[5])
    else $error("pin 5 flag missing");
  lower_vector_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [RL23]
    !nmiReq && srcReq == 20'h00003 && srcLevel[1:0] == 2'b00 |=> reqSource == 5'h00)
    else $error("vector order wrong");
  level_zero_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [RL12]
    !nmiReq && !hiFound && loFound |=> reqValid && !reqLevel)
    else $error("level 0 request wrong");
  adc_level_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [RL10]
    srcReq == 20'h20000 && !nmiReq |=> reqLevel == $past(prioB_q[1]) && reqSource == 5'h11)
    else $error("converter level wrong");
endmodule

// ### rtl/ipf_pick.sv
// Fixed-order pick of the lowest-numbered asserted source in a request vector.
`timescale 1ns/100ps
`include "ipf_params.svh"
module ipf_pick #(
  parameter int N = `IPF_SRC_COUNT
) (
  input wire logic [N-1:0] req,
  output logic found,
  output ipf_pkg::ipf_src_t index
);
  always_comb begin
    found = 1'b0;
    index = `IPF_NONE_CODE;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        index = ipf_pkg::ipf_src_t'(i);
      end
    end
  end
endmodule

// ### verif/ipf_cpu_model.sv
// Model of the core's exception handling that acknowledges presented pin requests.
`timescale 1ns/100ps
module ipf_cpu_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic handleEn,
  input wire logic reqValid,
  input wire ipf_pkg::ipf_src_t reqSource,
  output logic [5:0] pinHandled
);
  // Handling of a presented pin request is one pulse, then a pause cycle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinHandled <= 6'h00;
    end else if (handleEn && reqValid && reqSource < 5'h06 && pinHandled == 6'h00) begin
      pinHandled <= 6'h01 << reqSource;
    end else begin
      pinHandled <= 6'h00;
    end
  end
endmodule

// ### verif/irq_priority_and_flags_test.sv
// Self-checking testbench for the priority and flag block.
`timescale 1ns/100ps
`include "ipf_params.svh"
module irq_priority_and_flags_test;
  localparam logic [15:0] PAIR [12] = '{16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0080,
    16'h0040, 16'h0020, 16'h0008, 16'h0004, 16'h0002, 16'h0011, 16'h0000};
  localparam logic [4:0] SRC [12] = '{5'h06, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
    5'h0f, 5'h10, 5'h11, 5'h06, 5'h06};
  localparam logic [11:0] LVL = 12'h3ff;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hwStandby = 1'b0;
  logic nmiReq = 1'b0;
  logic handleEn = 1'b0;
  logic [5:0] pinN = 6'h3f;
  logic [13:0] intReq = 14'h0000;
  logic [5:0] handled;
  logic reqValid, reqLevel, awready, wready, bvalid, arready, rvalid;
  ipf_pkg::ipf_src_t reqSource;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  int numErrors = 0;
  int totalChecks = 0;

  always #50 core_clk = ~core_clk;

  ipf_ctrl u_dut (
    .core_clk(core_clk), .rstn(rstn), .hwStandby(hwStandby), .externalRequestPinN(pinN),
    .nmiReq(nmiReq), .internalReq(intReq), .pinHandled(handled), .reqValid(reqValid),
    .reqSource(reqSource), .reqLevel(reqLevel), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ipf_cpu_model u_cpu (.core_clk(core_clk), .rstn(rstn), .handleEn(handleEn),
    .reqValid(reqValid), .reqSource(reqSource), .pinHandled(handled));

  task automatic stop_test;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic awT, wT, bT;
    int n;
    bT = 1'b0;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((awvalid || wvalid || !bT) && n < 100) begin
      @(negedge core_clk);
      awT = awvalid && awready;
      wT = wvalid && wready;
      bT = bvalid;
      @(posedge core_clk);
      if (awT) awvalid <= 1'b0;
      if (wT) wvalid <= 1'b0;
      if (bT) bready <= 1'b0;
      n++;
    end
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
    logic arT, rT;
    logic [31:0] d;
    int n;
    rT = 1'b0;
    n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rT && n < 100) begin
      @(negedge core_clk);
      arT = arvalid && arready;
      rT = rvalid;
      d = rdata;
      @(posedge core_clk);
      if (arT) arvalid <= 1'b0;
      if (rT) rready <= 1'b0;
      n++;
    end
    chk(what, e, d);
  endtask

  task automatic settle;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic reqc(input logic lvl, input logic [4:0] src);
    chk("request", {25'h0, 1'b1, lvl, src}, {25'h0, reqValid, reqLevel, reqSource});
  endtask

  task automatic testReset;
    rdc("prio a", `IPF_OFF_PRIO_A, 32'h0);
    rdc("prio b", `IPF_OFF_PRIO_B, 32'h0);
    rdc("flags", `IPF_OFF_FLAGS, 32'h0);
    rdc("unmapped", `IPF_OFF_STANDBY, 32'h0);
  endtask

  task automatic testRegs;
    wr(`IPF_OFF_PRIO_A, 8'h5a);
    rdc("prio a", `IPF_OFF_PRIO_A, 32'h5a);
    wr(`IPF_OFF_PRIO_B, 8'hff);
    rdc("prio b", `IPF_OFF_PRIO_B, 32'hff);
    wr(`IPF_OFF_FLAGS, 8'hff);
    rdc("flags", `IPF_OFF_FLAGS, 32'h0);
  endtask

  task automatic testLevels;
    intReq <= 14'h3fff;
    for (int i = 0; i < 12; i++) begin
      wr(`IPF_OFF_PRIO_A, PAIR[i][15:8]);
      wr(`IPF_OFF_PRIO_B, PAIR[i][7:0]);
      settle();
      reqc(LVL[i], SRC[i]);
    end
    intReq <= 14'h0020;
    settle();
    reqc(1'b0, 5'h0d);
    intReq <= 14'h0200;
    settle();
    reqc(1'b0, 5'h11);
  endtask

  task automatic testNmi;
    wr(`IPF_OFF_PRIO_A, 8'h08);
    nmiReq <= 1'b1;
    settle();
    reqc(1'b1, `IPF_NMI_CODE);
    rdc("status", `IPF_OFF_STATUS, 32'hdf);
    nmiReq <= 1'b0;
    intReq <= 14'h0000;
  endtask

  task automatic testPinLevel;
    wr(`IPF_OFF_PRIO_A, 8'h80);
    pinN <= 6'h3e;
    settle();
    rdc("flags", `IPF_OFF_FLAGS, 32'h01);
    reqc(1'b1, 5'h00);
    handleEn <= 1'b1;
    settle();
    rdc("flags", `IPF_OFF_FLAGS, 32'h01);
    pinN <= 6'h3f;
    settle();
    rdc("flags", `IPF_OFF_FLAGS, 32'h00);
    handleEn <= 1'b0;
  endtask

  task automatic testPinEdge;
    wr(`IPF_OFF_SENSE, 8'h22);
    wr(`IPF_OFF_PRIO_A, 8'h10);
    intReq <= 14'h1000;
    pinN <= 6'h1f;
    settle();
    rdc("flags", `IPF_OFF_FLAGS, 32'h20);
    reqc(1'b1, 5'h05);
    handleEn <= 1'b1;
    settle();
    rdc("flags", `IPF_OFF_FLAGS, 32'h00);
    reqc(1'b0, 5'h06);
    handleEn <= 1'b0;
    pinN <= 6'h1d;
    settle();
    rdc("flags", `IPF_OFF_FLAGS, 32'h02);
    wr(`IPF_OFF_FLAGS, 8'h00);
    rdc("flags", `IPF_OFF_FLAGS, 32'h00);
    wr(`IPF_OFF_FLAGS, 8'hff);
    rdc("flags", `IPF_OFF_FLAGS, 32'h00);
    pinN <= 6'h3f;
    intReq <= 14'h0000;
  endtask

  task automatic testStandby;
    wr(`IPF_OFF_PRIO_A, 8'hff);
    hwStandby <= 1'b1;
    repeat (2) @(posedge core_clk);
    hwStandby <= 1'b0;
    rdc("prio a", `IPF_OFF_PRIO_A, 32'h0);
    rdc("sense", `IPF_OFF_SENSE, 32'h0);
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    testReset();
    testRegs();
    testLevels();
    testNmi();
    testPinLevel();
    testPinEdge();
    testStandby();
    stop_test();
  end

  initial begin
    #2000000;
    numErrors++;
    stop_test();
  end
endmodule
